// file: oas_pkg.sv
// package for the operand address and status flag datapath
package oas_pkg;

  // =========================================================
  // status word layout (bit 15 is the msb of the word)
  localparam int ST_W          = 16;
  localparam int FLAG_LGT_POS  = 15;
  localparam int FLAG_AGT_POS  = 14;
  localparam int FLAG_EQ_POS   = 13;
  localparam int FLAG_CY_POS   = 12;
  localparam int FLAG_OV_POS   = 11;
  localparam int FLAG_PAR_POS  = 10;
  localparam int FLAG_XOP_POS  = 9;
  localparam int MASK_LSB_POS  = 0;
  localparam int MASK_W        = 4;
  localparam logic [15:0] ST_RESET_VAL = 16'h0000;
  localparam logic [15:0] SIGN_ONLY    = 16'h8000;
  localparam logic [4:0]  PAR_CNT_MAX  = 5'h08;

  // =========================================================
  // register port map
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_EA     = 4'h1;
  localparam logic [3:0] ADDR_PC     = 4'h2;
  localparam logic [3:0] ADDR_BITADR = 4'h3;

  // =========================================================
  // addressing modes
  typedef enum logic [3:0] {
    AM_SYMBOLIC  = 4'h1,
    AM_INDEXED   = 4'h2,
    AM_IMMEDIATE = 4'h4,
    AM_NONE      = 4'h8
  } oas_amode_t;

  // instruction classes for status update
  typedef enum logic [4:0] {
    OP_NONE, OP_ADD, OP_SUB, OP_CMP, OP_LOGIC, OP_MOV, OP_INC, OP_DEC,
    OP_NEG, OP_ABS, OP_SLA, OP_SHIFT, OP_COC, OP_CZC, OP_TB, OP_DIV,
    OP_SERIAL, OP_XOP, OP_LOAD_MASK_IMMEDIATE, OP_CONTEXT_RETURN, OP_JREL
  } oas_op_t;

  typedef struct packed {
    oas_op_t     op;
    logic        byte_sel;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] result;
    logic        carry_out;
    logic        last_shift_out;
    logic        sign_changed;
    logic [4:0]  bit_count;
    logic [15:0] instr;
  } oas_exec_t;

  typedef struct packed {
    oas_amode_t  mode;
    logic [15:0] next_word;
    logic [15:0] index_val;
  } oas_addr_t;

endpackage : oas_pkg

// file: oas_datapath.sv
// operand address forming and status flag update for the processor core
// ============================================================
//
// Decided for this implementation: the address map and the address-and-strobe port.
module oas_datapath
  import oas_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        clk_en_in,
  input  wire logic        exec_valid_in,
  input  wire oas_exec_t   exec_in,
  input  wire logic        addr_valid_in,
  input  wire oas_addr_t   addr_in,
  input  wire logic [15:0] pc_updated_in,
  input  wire logic [15:0] serial_base_reg_in,
  input  wire logic [15:0] saved_flags_reg_in,
  input  wire logic        serial_input_pin_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [15:0]      reg_rdata_out,
  output logic [15:0]      status_out,
  output logic [15:0]      eff_addr_out,
  output logic             operand_is_value_out,
  output logic [15:0]      pc_out,
  output logic             pc_load_out,
  output logic [15:0]      bit_addr_out,
  output logic             byte_op_out
);

  // ============================================================
  // serial input synchroniser: change counts when stages 2 and 3 agree
  logic [2:0] sin_sync_reg;
  logic       sin_level_reg;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sin_sync_reg  <= 3'h0;
      sin_level_reg <= 1'b0;
    end else if (clk_en_in) begin
      sin_sync_reg <= {sin_sync_reg[1:0], serial_input_pin_in};
      if (sin_sync_reg[1] == sin_sync_reg[2]) begin
        sin_level_reg <= sin_sync_reg[2];
      end
    end
  end

  // ============================================================
  // address forming
  logic [15:0] ea_next;
  logic [15:0] jump_target;
  logic [15:0] bit_addr_next;
  logic [15:0] disp_ext;
  logic [15:0] serial_base;

  assign disp_ext    = {{8{exec_in.instr[7]}}, exec_in.instr[7:0]};
  assign jump_target = pc_updated_in + {disp_ext[14:0], 1'b0};
  assign serial_base = {4'h0, serial_base_reg_in[12:1]};
  assign bit_addr_next = serial_base + disp_ext;

  always_comb begin
    ea_next = 16'h0000;
    if (addr_in.mode == AM_SYMBOLIC) begin
      ea_next = addr_in.next_word;
    end else if (addr_in.mode == AM_INDEXED) begin
      ea_next = addr_in.next_word + addr_in.index_val;
    end else if (addr_in.mode == AM_IMMEDIATE) begin
      ea_next = addr_in.next_word;
    end
  end

  logic [15:0] ea_reg;
  logic        imm_reg;
  logic [15:0] pc_reg;
  logic        pc_load_reg;
  logic [15:0] bit_addr_reg;
  logic        byte_reg;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ea_reg  <= 16'h0000;
      imm_reg <= 1'b0;
    end else if (clk_en_in && addr_valid_in) begin
      ea_reg  <= ea_next;
      imm_reg <= (addr_in.mode == AM_IMMEDIATE);
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pc_reg       <= 16'h0000;
      pc_load_reg  <= 1'b0;
      bit_addr_reg <= 16'h0000;
      byte_reg     <= 1'b0;
    end else if (clk_en_in) begin
      pc_load_reg <= exec_valid_in && (exec_in.op == OP_JREL);
      if (exec_valid_in && exec_in.op == OP_JREL) begin
        pc_reg <= jump_target;
      end
      // only the single-bit test updates the bit address from the displacement in its low byte
      if (exec_valid_in && exec_in.op == OP_TB) begin
        bit_addr_reg <= bit_addr_next;
      end
      if (exec_valid_in) begin
        byte_reg <= exec_in.byte_sel;
      end
    end
  end

  // ============================================================
  // status flag computation
  // byte operands sit in the left byte; flags look at the top eight bits
  logic [15:0] res_v;
  logic [15:0] src_v;
  logic [15:0] dst_v;
  logic [15:0] diff_v;
  logic        ms, md, mr, mdf;
  logic        res_nz;
  logic        src_par;
  logic        res_par;

  always_comb begin
    res_v  = exec_in.byte_sel ? {exec_in.result[15:8], 8'h00} : exec_in.result;
    src_v  = exec_in.byte_sel ? {exec_in.src[15:8], 8'h00} : exec_in.src;
    dst_v  = exec_in.byte_sel ? {exec_in.dst[15:8], 8'h00} : exec_in.dst;
    diff_v = dst_v - src_v;
    ms     = src_v[15];
    md     = dst_v[15];
    mr     = res_v[15];
    mdf    = diff_v[15];
    res_nz = (res_v != 16'h0000);
    src_par = ^exec_in.src[15:8];
    res_par = ^exec_in.result[15:8];
  end

  logic [6:0] flags_reg;
  logic [6:0] flags_next;
  logic [3:0] mask_reg;

  always_comb begin
    flags_next = flags_reg;
    case (exec_in.op)
      OP_CMP: begin
        flags_next[6] = (ms & ~md) | ((ms == md) & mdf);
        flags_next[5] = (~ms & md) | ((ms == md) & mdf);
        flags_next[4] = (src_v == dst_v);
        if (exec_in.byte_sel) begin
          flags_next[1] = src_par;
        end
      end
      OP_ADD, OP_SUB: begin
        flags_next[6] = res_nz;
        flags_next[5] = res_nz & ~mr;
        flags_next[4] = ~res_nz;
        flags_next[3] = exec_in.carry_out;
        if (exec_in.op == OP_ADD) begin
          flags_next[2] = (ms == md) & (mr != md);
        end else begin
          flags_next[2] = (ms != md) & (mr != md);
        end
        if (exec_in.byte_sel) begin
          flags_next[1] = res_par;
        end
      end
      OP_LOGIC, OP_MOV: begin
        flags_next[6] = res_nz;
        flags_next[5] = res_nz & ~mr;
        flags_next[4] = ~res_nz;
        if (exec_in.byte_sel) begin
          flags_next[1] = (exec_in.op == OP_MOV) ? src_par : res_par;
        end
      end
      OP_INC, OP_DEC, OP_NEG: begin
        flags_next[6] = res_nz;
        flags_next[5] = res_nz & ~mr;
        flags_next[4] = ~res_nz;
        flags_next[3] = exec_in.carry_out;
        if (exec_in.op == OP_INC) begin
          flags_next[2] = ~ms & mr;
        end else if (exec_in.op == OP_DEC) begin
          flags_next[2] = ms & ~mr;
        end else begin
          flags_next[2] = (exec_in.src == SIGN_ONLY);
        end
      end
      OP_ABS: begin
        flags_next[6] = (exec_in.src != 16'h0000);
        flags_next[5] = ~exec_in.src[15] & (exec_in.src != 16'h0000);
        flags_next[4] = (exec_in.src == 16'h0000);
        flags_next[3] = exec_in.carry_out;
        flags_next[2] = (exec_in.src == SIGN_ONLY);
      end
      OP_SLA, OP_SHIFT: begin
        flags_next[6] = res_nz;
        flags_next[5] = res_nz & ~mr;
        flags_next[4] = ~res_nz;
        flags_next[3] = exec_in.last_shift_out;
        if (exec_in.op == OP_SLA) begin
          flags_next[2] = exec_in.sign_changed;
        end
      end
      OP_COC: flags_next[4] = ((exec_in.src & ~exec_in.dst) == 16'h0000);
      OP_CZC: flags_next[4] = ((exec_in.src & exec_in.dst) == 16'h0000);
      OP_TB:  flags_next[4] = sin_level_reg;
      OP_DIV: flags_next[2] = (~ms & md) | ((ms == md) & ~mdf);
      OP_SERIAL: begin
        flags_next[6] = res_nz;
        flags_next[5] = res_nz & ~mr;
        flags_next[4] = ~res_nz;
        flags_next[1] = (exec_in.bit_count >= 5'h01) && (exec_in.bit_count <= PAR_CNT_MAX)
                        && src_par;
      end
      OP_XOP:  flags_next[0] = 1'b1;
      default: flags_next = flags_reg;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_reg <= ST_RESET_VAL[15:9];
    end else if (clk_en_in) begin
      if (reg_wr_in && reg_addr_in == ADDR_STATUS) begin
        flags_reg <= reg_wdata_in[FLAG_LGT_POS:FLAG_XOP_POS];
      end else if (exec_valid_in) begin
        flags_reg <= flags_next;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mask_reg <= ST_RESET_VAL[3:0];
    end else if (clk_en_in) begin
      if (reg_wr_in && reg_addr_in == ADDR_STATUS) begin
        mask_reg <= reg_wdata_in[MASK_W-1:MASK_LSB_POS];
      end else if (exec_valid_in && exec_in.op == OP_LOAD_MASK_IMMEDIATE) begin
        mask_reg <= exec_in.src[MASK_W-1:0];
      end else if (exec_valid_in && exec_in.op == OP_CONTEXT_RETURN) begin
        mask_reg <= saved_flags_reg_in[MASK_W-1:0];
      end
    end
  end

  // ============================================================
  // register port and outputs
  logic [15:0] status_word;
  assign status_word = {flags_reg, 5'h00, mask_reg};

  logic [15:0] rdata_reg;
  logic [15:0] status_reg;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg  <= 16'h0000;
      status_reg <= ST_RESET_VAL;
    end else if (clk_en_in) begin
      status_reg <= status_word;
      rdata_reg  <= 16'h0000;
      if (reg_rd_in) begin
        if (reg_addr_in == ADDR_STATUS) begin
          rdata_reg <= status_word;
        end else if (reg_addr_in == ADDR_EA) begin
          rdata_reg <= ea_reg;
        end else if (reg_addr_in == ADDR_PC) begin
          rdata_reg <= pc_reg;
        end else if (reg_addr_in == ADDR_BITADR) begin
          rdata_reg <= bit_addr_reg;
        end
      end
    end
  end

  assign reg_rdata_out        = rdata_reg;
  assign status_out           = status_reg;
  assign eff_addr_out         = ea_reg;
  assign operand_is_value_out = imm_reg;
  assign pc_out               = pc_reg;
  assign pc_load_out          = pc_load_reg;
  assign bit_addr_out         = bit_addr_reg;
  assign byte_op_out          = byte_reg;

  // ============================================================
  // checks
  sequence s_xop_exec;
    clk_en_in && exec_valid_in && exec_in.op == OP_XOP && !reg_wr_in;
  endsequence

  chk_xop_sets_flag: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    s_xop_exec |=> flags_reg[0]) else $error("xop flag not set");

  chk_reserved_zero: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    status_word[8:4] == 5'h00) else $error("reserved status bits nonzero");

  chk_jump_target: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    clk_en_in && exec_valid_in && exec_in.op == OP_JREL
    |=> pc_load_reg && pc_reg == $past(pc_updated_in) + {{7{$past(exec_in.instr[7])}}, $past(exec_in.instr[7:0]), 1'b0})
    else $error("relative jump target wrong");

  chk_symbolic_addr: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    clk_en_in && addr_valid_in && addr_in.mode == AM_SYMBOLIC |=> ea_reg == $past(addr_in.next_word) && !imm_reg)
    else $error("symbolic address wrong");

  chk_indexed_addr: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    clk_en_in && addr_valid_in && addr_in.mode == AM_INDEXED
    |=> ea_reg == $past(addr_in.next_word) + $past(addr_in.index_val)) else $error("indexed address wrong");

  chk_load_mask_immediate_mask: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    clk_en_in && exec_valid_in && exec_in.op == OP_LOAD_MASK_IMMEDIATE && !reg_wr_in
    |=> mask_reg == $past(exec_in.src[3:0])) else $error("mask not loaded");

  chk_unaffected_keep: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    clk_en_in && exec_valid_in && exec_in.op == OP_COC && !reg_wr_in
    |=> flags_reg[6:5] == $past(flags_reg[6:5]) && flags_reg[3:0] == $past(flags_reg[3:0]))
    else $error("unaffected flag changed");

  chk_status_out: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    clk_en_in |=> status_out == $past(status_word)) else $error("status output stale");

endmodule // oas_datapath

// file: oas_datapath_tb.sv
// self-checking testbench for the operand address and status flag datapath
module oas_datapath_tb
  import oas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // stimulus, observed outputs and counters
  logic        ref_clk_in          = 1'h0;
  logic        rst_in              = 1'h1;
  logic        exec_valid_in       = 1'h0;
  oas_exec_t   exec_in             = '0;
  logic        addr_valid_in       = 1'h0;
  oas_addr_t   addr_in             = '0;
  logic [15:0] pc_updated_in       = 16'h0000;
  logic [15:0] serial_base_reg_in  = 16'h0000;
  logic        serial_input_pin_in = 1'h0;
  logic [3:0]  reg_addr_in         = 4'h0;
  logic [15:0] reg_wdata_in        = 16'h0000;
  logic        reg_wr_in           = 1'h0;
  logic        reg_rd_in           = 1'h0;
  logic        clk_en_in           = 1'h1;
  logic [15:0] saved_flags_reg_in  = 16'h0006;
  logic [15:0] reg_rdata_out, status_out, eff_addr_out, pc_out, bit_addr_out;
  logic        operand_is_value_out, pc_load_out, byte_op_out;
  int          n_mismatch          = 0;
  int          tests_run           = 0;

  always #50 ref_clk_in = ~ref_clk_in;

  // enable and saved flags are bench variables so that freeze and restore can be varied
  oas_datapath dut_u (
    .ref_clk_in, .rst_in, .clk_en_in, .exec_valid_in, .exec_in, .addr_valid_in, .addr_in,
    .pc_updated_in, .serial_base_reg_in, .saved_flags_reg_in, .serial_input_pin_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .status_out, .eff_addr_out,
    .operand_is_value_out, .pc_out, .pc_load_out, .bit_addr_out, .byte_op_out
  );

  // ==========================================================
  // instruction table: preset status, then expected status
  typedef struct packed {
    oas_op_t     op;
    logic        b;
    logic [15:0] src, dst, res;
    logic [2:0]  f;    // carry out, last bit shifted out, sign changed
    logic [4:0]  cnt;
    logic [15:0] pre, exp;
  } oas_row_t;

  oas_row_t rows [25] = '{
    '{OP_ADD,1'h0,16'h7fff,16'h0001,16'h8000,3'h0,5'h00,16'h060a,16'h8e0a},
    '{OP_SUB,1'h0,16'h0001,16'h8000,16'h7fff,3'h4,5'h00,16'h0000,16'hd800},
    '{OP_CMP,1'h0,16'h8000,16'h0001,16'h8001,3'h0,5'h00,16'h1e05,16'h9e05},
    '{OP_CMP,1'h0,16'h1234,16'h1234,16'h0000,3'h0,5'h00,16'hc000,16'h2000},
    '{OP_CMP,1'h0,16'h0001,16'h8000,16'h7fff,3'h0,5'h00,16'h0000,16'h4000},
    '{OP_INC,1'h0,16'h7fff,16'h0000,16'h8000,3'h0,5'h00,16'h0000,16'h8800},
    '{OP_DEC,1'h0,16'h8000,16'h0000,16'h7fff,3'h4,5'h00,16'h0000,16'hd800},
    '{OP_NEG,1'h0,16'h8000,16'h0000,16'h8000,3'h0,5'h00,16'h0000,16'h8800},
    '{OP_ABS,1'h0,16'h0000,16'h0000,16'h0000,3'h4,5'h00,16'h0000,16'h3000},
    '{OP_ABS,1'h0,16'hffff,16'h0000,16'h0001,3'h0,5'h00,16'h0000,16'h8000},
    '{OP_SLA,1'h0,16'h4000,16'h0000,16'h8000,3'h3,5'h00,16'h0000,16'h9800},
    '{OP_SHIFT,1'h0,16'h0001,16'h0000,16'h0000,3'h2,5'h00,16'h0800,16'h3800},
    '{OP_COC,1'h0,16'h00f0,16'h0ff0,16'h0000,3'h0,5'h00,16'hd000,16'hf000},
    '{OP_CZC,1'h0,16'h00f0,16'h0010,16'h0000,3'h0,5'h00,16'h2000,16'h0000},
    '{OP_DIV,1'h0,16'h0002,16'h0001,16'hffff,3'h0,5'h00,16'h0800,16'h0000},
    '{OP_DIV,1'h0,16'h0001,16'h0003,16'h0002,3'h0,5'h00,16'h0000,16'h0800},
    '{OP_XOP,1'h0,16'h0000,16'h0000,16'h0000,3'h0,5'h00,16'h0000,16'h0200},
    '{OP_LOAD_MASK_IMMEDIATE,1'h0,16'h0009,16'h0009,16'h0009,3'h0,5'h00,16'hfe06,16'hfe09},
    '{OP_CONTEXT_RETURN,1'h0,16'h0000,16'h0000,16'h0000,3'h0,5'h00,16'h0009,16'h0006},
    '{OP_ADD,1'h1,16'h0300,16'h0400,16'h0700,3'h0,5'h00,16'h0000,16'hc400},
    '{OP_MOV,1'h1,16'h8000,16'h0000,16'h8000,3'h0,5'h00,16'h0000,16'h8400},
    '{OP_LOGIC,1'h1,16'h0300,16'h0000,16'h0300,3'h0,5'h00,16'h0400,16'hc000},
    '{OP_CMP,1'h1,16'h0100,16'h0100,16'h0000,3'h0,5'h00,16'h0000,16'h2400},
    '{OP_SERIAL,1'h1,16'h0700,16'h0000,16'h0700,3'h0,5'h08,16'h0000,16'hc400},
    '{OP_SERIAL,1'h0,16'h0700,16'h0000,16'h0700,3'h0,5'h09,16'h0400,16'hc000}
  };

  // ==========================================================
  // bus and check helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t ns: got %h, expected %h", $time, seen, exp);
    end
  endtask

  function automatic oas_exec_t ex(input oas_op_t op, input logic [15:0] ins);
    ex = '0;
    ex.op = op;
    ex.instr = ins;
  endfunction

  function automatic oas_exec_t mk(input oas_row_t r);
    mk = ex(r.op, 16'h0000);
    mk.byte_sel = r.b;
    mk.src = r.src;
    mk.dst = r.dst;
    mk.result = r.res;
    {mk.carry_out, mk.last_shift_out, mk.sign_changed} = r.f;
    mk.bit_count = r.cnt;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'h1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'h0;
  endtask

  // read data stand only in the cycle after the strobe, so look there
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'h1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'h0;
    #1;
    chk(reg_rdata_out, e);
  endtask

  task automatic issue(input oas_exec_t e);
    @(posedge ref_clk_in);
    exec_in       <= e;
    exec_valid_in <= 1'h1;
    @(posedge ref_clk_in);
    exec_valid_in <= 1'h0;
    #1;
  endtask

  task automatic adr(input oas_amode_t m, input logic [15:0] nw, ix, ea, input logic v);
    @(posedge ref_clk_in);
    addr_in       <= '{m, nw, ix};
    addr_valid_in <= 1'h1;
    @(posedge ref_clk_in);
    addr_valid_in <= 1'h0;
    #1;
    if (m != AM_IMMEDIATE) begin
      chk(eff_addr_out, ea);
    end
    chk({15'h0000, operand_is_value_out}, {15'h0000, v});
  endtask

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk_in);
    n_mismatch++;
    end_of_test;
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge ref_clk_in);
    rst_in <= 1'h0;
    #1;
    chk(status_out, 16'h0000);
    foreach (rows[i]) begin
      wr(ADDR_STATUS, rows[i].pre);
      repeat (3) @(posedge ref_clk_in);
      issue(mk(rows[i]));
      repeat (2) @(posedge ref_clk_in);
      #1;
      chk(status_out, rows[i].exp);
      chk({15'h0000, byte_op_out}, {15'h0000, rows[i].b});
      rd(ADDR_STATUS, rows[i].exp);
    end
    adr(AM_SYMBOLIC, 16'h4a3c, 16'h1111, 16'h4a3c, 1'h0);
    adr(AM_INDEXED, 16'hfffe, 16'h0004, 16'h0002, 1'h0);
    rd(ADDR_EA, 16'h0002);
    adr(AM_IMMEDIATE, 16'h1234, 16'h0000, 16'h0000, 1'h1);
    adr(AM_SYMBOLIC, 16'h0100, 16'h0000, 16'h0100, 1'h0);
    // displacement sits under opcode bits, which must not leak into the sum
    wr(ADDR_STATUS, 16'hfe0f);
    pc_updated_in <= 16'h1000;
    issue(ex(OP_JREL, 16'h1080));
    chk(pc_out, 16'h0f00);
    chk({15'h0000, pc_load_out}, 16'h0001);
    @(posedge ref_clk_in);
    #1;
    chk({15'h0000, pc_load_out}, 16'h0000);
    issue(ex(OP_JREL, 16'h107f));
    chk(pc_out, 16'h10fe);
    rd(ADDR_PC, 16'h10fe);
    chk(status_out, 16'hfe0f);
    // serial pin passes a synchroniser, so let it settle before the test
    @(posedge ref_clk_in);
    serial_base_reg_in  <= 16'he247;
    serial_input_pin_in <= 1'h1;
    wr(ADDR_STATUS, 16'h0000);
    repeat (5) @(posedge ref_clk_in);
    issue(ex(OP_TB, 16'h1ffe));
    chk(bit_addr_out, 16'h0121);
    repeat (2) @(posedge ref_clk_in);
    #1;
    chk(status_out, 16'h2000);
    @(posedge ref_clk_in);
    serial_input_pin_in <= 1'h0;
    repeat (5) @(posedge ref_clk_in);
    issue(ex(OP_TB, 16'h1f05));
    chk(bit_addr_out, 16'h0128);
    rd(ADDR_BITADR, 16'h0128);
    chk(status_out, 16'h0000);
    @(posedge ref_clk_in);
    exec_in       <= ex(OP_XOP, 16'h0000);
    exec_valid_in <= 1'h1;
    @(posedge ref_clk_in);
    exec_in <= mk(rows[3]);
    @(posedge ref_clk_in);
    exec_valid_in <= 1'h0;
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk(status_out, 16'h2200);
    // a status write in the same cycle as an instruction takes priority
    @(posedge ref_clk_in);
    reg_addr_in   <= ADDR_STATUS;
    reg_wdata_in  <= 16'h0005;
    reg_wr_in     <= 1'h1;
    exec_in       <= ex(OP_XOP, 16'h0000);
    exec_valid_in <= 1'h1;
    @(posedge ref_clk_in);
    reg_wr_in     <= 1'h0;
    exec_valid_in <= 1'h0;
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk(status_out, 16'h0005);
    wr(4'h9, 16'hffff);
    rd(4'h9, 16'h0000);
    rd(ADDR_STATUS, 16'h0005);
    // with the enable low neither an instruction nor a status write may land
    @(posedge ref_clk_in);
    clk_en_in <= 1'h0;
    issue(ex(OP_XOP, 16'h0000));
    wr(ADDR_STATUS, 16'h0000);
    clk_en_in <= 1'h1;
    repeat (2) @(posedge ref_clk_in);
    #1;
    chk(status_out, 16'h0005);
    @(posedge ref_clk_in);
    saved_flags_reg_in <= 16'h000a;
    issue(ex(OP_CONTEXT_RETURN, 16'h0000));
    repeat (2) @(posedge ref_clk_in);
    #1;
    chk(status_out, 16'h000a);
    wr(ADDR_STATUS, 16'hffff);
    repeat (3) @(posedge ref_clk_in);
    rd(ADDR_STATUS, 16'hfe0f);
    @(posedge ref_clk_in);
    rst_in <= 1'h1;
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk(status_out, 16'h0000);
    chk(pc_out, 16'h0000);
    chk(eff_addr_out, 16'h0000);
    @(posedge ref_clk_in);
    rst_in <= 1'h0;
    @(posedge ref_clk_in);
    #1;
    chk(status_out, 16'h0000);
    end_of_test;
  end

endmodule // oas_datapath_tb
